// ---- common/lcs_pkg.sv ----
// lcs_pkg: register map, field layout and reset values of the cell input source stage
// assumes: included before the design modules that import it
`default_nettype none
package lcs_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int SEL_W = 3;
  localparam int NUM_SRC = 4;
  localparam int NUM_GATE = 4;
  // register indices on the plain port, chosen locally
  localparam logic [ADDR_W-1:0] OFS_SELECT = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_GATE_LOW = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_GATE_HIGH = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_POLARITY = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  // field positions inside the select register
  localparam int POS_SEL_A = 0;
  localparam int POS_SEL_B = 4;
  localparam int POS_SEL_C = 8;
  localparam int POS_SEL_D = 12;
  localparam logic [DATA_W-1:0] SELECT_MASK = 16'h7777;
  localparam logic [DATA_W-1:0] POL_MASK = 16'h000F;
  localparam logic [DATA_W-1:0] RST_SELECT = 16'h0000;
  localparam logic [DATA_W-1:0] RST_GATE = 16'h0000;
  localparam logic [DATA_W-1:0] RST_POL = 16'h0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
endpackage : lcs_pkg
`default_nettype wire

// ---- hdl/lcs_input_stage.sv ----
// lcs_input_stage: source selection and gate-enable matrix of one logic cell
// assumes: every source input synchronous to CLOCK; register port per the plain strobe bus
//
// The address-and-strobe port and the register offsets were left to the implementer.
`default_nettype none
module lcs_input_stage
  import lcs_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [lcs_pkg::ADDR_W-1:0] ADDR,
  input wire logic [lcs_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [lcs_pkg::DATA_W-1:0] RDATA,
  input wire logic CELL_PIN_IN_A,
  input wire logic CELL_PIN_IN_B,
  input wire logic CELL_PIN_IN_C,
  input wire logic CELL_PIN_IN_D,
  input wire logic INSTR_CYCLE_CLOCK,
  input wire logic LOW_POWER_RC_CLOCK,
  input wire logic REF_CLOCK_OUT,
  input wire logic [3:0] CC_AUX_OUT,
  input wire logic [3:0] CC_UNIT_FLAG,
  input wire logic [3:0] CELL_OUT,
  input wire logic [2:0] COMPARATOR_OUT,
  input wire logic PWM_EVENT_A,
  input wire logic SERIAL_DATA_IN,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_RX_OUT,
  input wire logic SERIAL_TX_IN,
  input wire logic SERIAL_ON_REMAP,
  output logic [3:0] SEL_TRUE,
  output logic [3:0] GATE_OUT
);
  import lcs_pkg::*;

  logic [DATA_W-1:0] select_reg;
  logic [DATA_W-1:0] gate_low_reg;
  logic [DATA_W-1:0] gate_high_reg;
  logic [DATA_W-1:0] pol_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [3:0] sel_true_reg;
  logic [3:0] gate_reg;
  logic [3:0] gate_next;
  logic [7:0] src_a;
  logic [7:0] src_b;
  logic [7:0] src_c;
  logic [7:0] src_d;
  logic [NUM_SRC-1:0] mux_true;
  logic [NUM_SRC-1:0] mux_inv;
  logic [7:0] mux_pair;
  logic [31:0] gate_en;
  logic sdi_ok;
  logic sdo_ok;
  logic wr_en;

  // serial data is undefined off the remap path; forced low so gates stay deterministic
  assign sdi_ok = SERIAL_DATA_IN & SERIAL_ON_REMAP;
  assign sdo_ok = SERIAL_DATA_OUT & SERIAL_ON_REMAP;

  // one write qualifier, so a frozen clock enable blocks every register alike
  assign wr_en = CE & WR;

  // reserved codes feed a constant low so a stray code cannot float a gate
  always_comb begin
    src_a = 8'h00;
    src_a[0] = CELL_PIN_IN_A;
    src_a[1] = INSTR_CYCLE_CLOCK;
    src_a[2] = CELL_OUT[2];
    src_a[3] = LOW_POWER_RC_CLOCK;
    src_a[4] = REF_CLOCK_OUT;
    src_a[6] = CC_AUX_OUT[1];
    src_a[7] = CC_AUX_OUT[3];
  end
  always_comb begin
    src_b = 8'h00;
    src_b[0] = CELL_PIN_IN_B;
    src_b[2] = COMPARATOR_OUT[0];
    src_b[3] = SERIAL_TX_IN;
    src_b[6] = CC_UNIT_FLAG[0];
    src_b[7] = CC_UNIT_FLAG[1];
  end
  // serial lines are this cell's own port instance, wired in by the integrator
  always_comb begin
    src_c = 8'h00;
    src_c[0] = CELL_PIN_IN_C;
    src_c[1] = CELL_OUT[0];
    src_c[2] = COMPARATOR_OUT[1];
    src_c[3] = sdo_ok;
    src_c[4] = SERIAL_RX_OUT;
    src_c[5] = CELL_OUT[3];
    src_c[6] = CC_UNIT_FLAG[2];
    src_c[7] = CC_UNIT_FLAG[3];
  end
  always_comb begin
    src_d = 8'h00;
    src_d[0] = PWM_EVENT_A;
    src_d[1] = CELL_OUT[1];
    src_d[2] = COMPARATOR_OUT[2];
    src_d[3] = sdi_ok;
    src_d[5] = CELL_PIN_IN_D;
    src_d[6] = CC_AUX_OUT[0];
    src_d[7] = CC_AUX_OUT[2];
  end

  lcs_src_mux u_mux_a (
    .sel(select_reg[POS_SEL_A +: SEL_W]),
    .src(src_a),
    .sel_true(mux_true[0]),
    .sel_inv(mux_inv[0])
  );
  lcs_src_mux u_mux_b (
    .sel(select_reg[POS_SEL_B +: SEL_W]),
    .src(src_b),
    .sel_true(mux_true[1]),
    .sel_inv(mux_inv[1])
  );
  lcs_src_mux u_mux_c (
    .sel(select_reg[POS_SEL_C +: SEL_W]),
    .src(src_c),
    .sel_true(mux_true[2]),
    .sel_inv(mux_inv[2])
  );
  lcs_src_mux u_mux_d (
    .sel(select_reg[POS_SEL_D +: SEL_W]),
    .src(src_d),
    .sel_true(mux_true[3]),
    .sel_inv(mux_inv[3])
  );

  // per gate byte: bit 2k+1 true enable, bit 2k negated enable of source k
  assign mux_pair = {mux_true[3], mux_inv[3], mux_true[2], mux_inv[2],
                     mux_true[1], mux_inv[1], mux_true[0], mux_inv[0]};
  assign gate_en = {gate_high_reg, gate_low_reg};

  always_comb begin
    for (int g = 0; g < NUM_GATE; g++) begin
      // empty enable byte ORs to zero, then polarity flips it
      gate_next[g] = (|(gate_en[8*g +: 8] & mux_pair)) ^ pol_reg[g];
    end
  end

  // select register kept apart: its mask is what makes the unused bits read zero
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      select_reg <= RST_SELECT;
    end else if (wr_en && ADDR == OFS_SELECT) begin
      select_reg <= WDATA & SELECT_MASK;
    end
  end

  // gate enables and polarity: writes honour only implemented bits
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      gate_low_reg <= RST_GATE;
      gate_high_reg <= RST_GATE;
      pol_reg <= RST_POL;
    end else if (wr_en) begin
      case (ADDR)
        OFS_GATE_LOW: gate_low_reg <= WDATA;
        OFS_GATE_HIGH: gate_high_reg <= WDATA;
        OFS_POLARITY: pol_reg <= WDATA & POL_MASK;
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe, and is held unchanged while CE is low
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= READ_ZERO;
    end else if (CE) begin
      if (RD) begin
        case (ADDR)
          OFS_SELECT: rdata_reg <= select_reg;
          OFS_GATE_LOW: rdata_reg <= gate_low_reg;
          OFS_GATE_HIGH: rdata_reg <= gate_high_reg;
          OFS_POLARITY: rdata_reg <= pol_reg;
          OFS_STATUS: rdata_reg <= {8'h00, gate_reg, sel_true_reg};
          default: rdata_reg <= READ_ZERO;
        endcase
      end else begin
        rdata_reg <= READ_ZERO;
      end
    end
  end

  // outputs registered for clean timing; costs one cycle at the pins and in the status word
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sel_true_reg <= 4'h0;
    end else if (CE) begin
      sel_true_reg <= mux_true;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      gate_reg <= 4'h0;
    end else if (CE) begin
      gate_reg <= gate_next;
    end
  end

  assign RDATA = rdata_reg;
  assign SEL_TRUE = sel_true_reg;
  assign GATE_OUT = gate_reg;
endmodule : lcs_input_stage
`default_nettype wire

// ---- hdl/lcs_src_mux.sv ----
// lcs_src_mux: one eight-way data source selector with true and negated outputs
// assumes: sources already synchronous to the cell clock; reserved codes tied low by the caller
`default_nettype none
module lcs_src_mux (
  input wire logic [2:0] sel,
  input wire logic [7:0] src,
  output logic sel_true,
  output logic sel_inv
);
  // purely combinational so a new code acts at once
  always_comb begin
    sel_true = src[sel];
    sel_inv = ~src[sel];
  end
endmodule : lcs_src_mux
`default_nettype wire

// ---- test/lcs_input_stage_properties.sv ----
// checker: register port and selector timing of the input stage
// assumes: bound to lcs_input_stage; every assertion is qualified by CE, the serial cover is not
`default_nettype none
module lcs_input_stage_chk (
  input wire logic CLOCK, RSTN, CE, WR, RD, SERIAL_ON_REMAP,
  input wire logic CELL_PIN_IN_A, CELL_PIN_IN_B, CELL_PIN_IN_D,
  input wire logic [3:0] ADDR, SEL_TRUE, CC_UNIT_FLAG,
  input wire logic [15:0] WDATA, RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sel_q;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // shadow of the select register, so source codes are visible here
  always_ff @(posedge CLOCK or negedge RSTN)
    if (!RSTN) sel_q <= 16'h0000;
    else if (CE && WR && ADDR == 4'h0) sel_q <= WDATA & 16'h7777;
  rd_idle_zero_a: assert property (CE && !RD |=> RDATA == 16'h0000)
    else $error("read data not idle");
  sel_gap_zero_a: assert property (CE && RD && ADDR == 4'h0 |=> !(|(RDATA & 16'h8888)))
    else $error("unused select bits set");
  status_copy_a: assert property (CE && RD && ADDR == 4'h4 |=> RDATA[3:0] == $past(SEL_TRUE))
    else $error("status mismatch");
  src_a_pin_a: assert property (CE && sel_q[2:0] == 3'h0 |=> SEL_TRUE[0] == $past(CELL_PIN_IN_A))
    else $error("selector a pin");
  src_b_pin_a: assert property (CE && sel_q[6:4] == 3'h0 |=> SEL_TRUE[1] == $past(CELL_PIN_IN_B))
    else $error("selector b pin");
  src_c_flag_a: assert property (CE && sel_q[10:8] == 3'h7 |=> SEL_TRUE[2] == $past(CC_UNIT_FLAG[3]))
    else $error("selector c flag");
  src_d_pin_a: assert property (CE && sel_q[14:12] == 3'h5 |=> SEL_TRUE[3] == $past(CELL_PIN_IN_D))
    else $error("selector d pin");
  serial_off_a: assert property (CE && !SERIAL_ON_REMAP && sel_q[14:12] == 3'h3 |=> !SEL_TRUE[3])
    else $error("serial not masked");
  cover property (CE && WR && ADDR == 4'h0);
  cover property (CE && RD && ADDR == 4'h4);
  cover property (!SERIAL_ON_REMAP && sel_q[14:12] == 3'h3);
endmodule : lcs_input_stage_chk
bind lcs_input_stage lcs_input_stage_chk u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .CE(CE), .WR(WR),
  .RD(RD), .SERIAL_ON_REMAP(SERIAL_ON_REMAP), .CELL_PIN_IN_A(CELL_PIN_IN_A),
  .CELL_PIN_IN_B(CELL_PIN_IN_B), .CELL_PIN_IN_D(CELL_PIN_IN_D), .ADDR(ADDR),
  .SEL_TRUE(SEL_TRUE), .CC_UNIT_FLAG(CC_UNIT_FLAG), .WDATA(WDATA), .RDATA(RDATA));
`default_nettype wire

// ---- test/lcs_input_stage_tb_top.sv ----
// lcs_input_stage_tb_top: random selector and gate checks over the register port
// assumes: lcs_pkg compiled first, checker bound, source model beside the design
`default_nettype none
module lcs_input_stage_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lcs_pkg::*;
  logic clock = 0, rstn = 0, wr = 0, rd_s = 0, remap = 0, ce = 1;
  logic [3:0] addr = 0, es, eg, pol, so, go;
  logic [15:0] wdata = 0, sel, gl, gh, rdata;
  logic [26:0] nxt = 0, s;
  int n_fail = 0, checks_done = 0;
  always #20 clock = ~clock;
  lcs_input_stage u_lcs_input_stage (.CLOCK(clock), .RSTN(rstn), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd_s), .RDATA(rdata), .CELL_PIN_IN_A(s[0]), .CELL_PIN_IN_B(s[1]),
    .CELL_PIN_IN_C(s[2]), .CELL_PIN_IN_D(s[3]), .INSTR_CYCLE_CLOCK(s[4]),
    .LOW_POWER_RC_CLOCK(s[5]), .REF_CLOCK_OUT(s[6]), .CC_AUX_OUT(s[10:7]),
    .CC_UNIT_FLAG(s[14:11]), .CELL_OUT(s[18:15]), .COMPARATOR_OUT(s[21:19]),
    .PWM_EVENT_A(s[22]), .SERIAL_DATA_IN(s[23]), .SERIAL_DATA_OUT(s[24]),
    .SERIAL_RX_OUT(s[25]), .SERIAL_TX_IN(s[26]), .SERIAL_ON_REMAP(remap),
    .SEL_TRUE(so), .GATE_OUT(go));
  lcs_src_model u_lcs_src_model (.CLOCK(clock), .nxt(nxt), .src(s));
  function automatic logic [3:0] exp_sel(logic [15:0] c, logic [26:0] v, logic r);
    logic [7:0] m [4];
    m[0] = {v[10], v[8], 1'h0, v[6], v[5], v[17], v[4], v[0]};
    m[1] = {v[12], v[11], 2'h0, v[26], v[19], 1'h0, v[1]};
    m[2] = {v[14:13], v[18], v[25], v[24] & r, v[20], v[15], v[2]};
    m[3] = {v[9], v[7], v[3], 1'h0, v[23] & r, v[21], v[16], v[22]};
    for (int i = 0; i < 4; i++) exp_sel[i] = m[i][c[4*i+:3]];
  endfunction : exp_sel
  function automatic logic exp_gate(logic [7:0] e, logic [3:0] v, logic p);
    logic o;
    o = 1'h0;
    for (int k = 0; k < 4; k++) o |= e[2*k+1] & v[k] | e[2*k] & ~v[k];
    return o ^ p;
  endfunction : exp_gate
  task automatic chk(logic [15:0] got, logic [15:0] e);
    checks_done++;
    if (got !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, e);
    end
  endtask : chk
  task automatic chk_out(logic [3:0] got, logic [3:0] e);
    checks_done++;
    if (got !== e) begin
      n_fail++;
      $display("[FAIL] %0t pin got %h want %h", $time, got, e);
    end
  endtask : chk_out
  task automatic wr_reg(logic [3:0] a, logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(logic [3:0] a, logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clock);
    rd_s <= 1'h0;
    #1 chk(rdata, e);
  endtask : rd_reg
  task automatic test_done;
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    void'($urandom(25));
    repeat (12) @(posedge clock);
    rstn <= 1'h1;
    for (int a = 0; a < 8; a++) rd_reg(a[3:0], RST_SELECT);
    wr_reg(OFS_SELECT, 16'hFFFF);
    rd_reg(OFS_SELECT, SELECT_MASK);
    wr_reg(OFS_POLARITY, 16'hFFFF);
    rd_reg(OFS_POLARITY, POL_MASK);
    for (int i = 0; i < 300; i++) begin
      sel = 16'($urandom) & SELECT_MASK;
      {gl, gh} = (i < 4) ? 32'h0 : 32'($urandom);
      pol = 4'($urandom);
      if (sel[2:0] == 3'h5) sel[2:0] = 3'h0;
      if (sel[6:4] inside {3'h1, 3'h4, 3'h5}) sel[6:4] = 3'h0;
      if (sel[14:12] == 3'h4) sel[14:12] = 3'h0;
      wr_reg(OFS_SELECT, sel);
      wr_reg(OFS_GATE_LOW, gl);
      wr_reg(OFS_GATE_HIGH, gh);
      wr_reg(OFS_POLARITY, {12'h000, pol});
      nxt <= 27'($urandom);
      remap <= 1'($urandom);
      repeat (3) @(posedge clock);
      #1;
      es = exp_sel(sel, nxt, remap);
      eg = {exp_gate(gh[15:8], es, pol[3]), exp_gate(gh[7:0], es, pol[2]),
        exp_gate(gl[15:8], es, pol[1]), exp_gate(gl[7:0], es, pol[0])};
      chk_out(so, es);
      chk_out(go, eg);
      rd_reg(OFS_STATUS, {8'h00, eg, es});
    end
    // clock enable low: sources move and a write comes, yet nothing may change
    @(posedge clock);
    ce <= 1'h0;
    nxt <= ~nxt;
    wr_reg(OFS_POLARITY, {12'h000, ~pol});
    repeat (3) @(posedge clock);
    #1;
    chk_out(so, es);
    chk_out(go, eg);
    @(posedge clock);
    ce <= 1'h1;
    rd_reg(OFS_POLARITY, {12'h000, pol});
    chk_out(so, exp_sel(sel, nxt, remap));
    test_done();
  end
endmodule : lcs_input_stage_tb_top
`default_nettype wire

// ---- test/lcs_src_model.sv ----
// lcs_src_model: on-chip peripherals and pins as one source word
// assumes: sources move just after a rising edge, like on-chip logic
`default_nettype none
module lcs_src_model (
  input wire logic CLOCK,
  input wire logic [26:0] nxt,
  output logic [26:0] src
);
  timeunit 1ns;
  timeprecision 1ns;
  // registered so a source never changes in mid-cycle
  always_ff @(posedge CLOCK) src <= nxt;
endmodule : lcs_src_model
`default_nettype wire
